// ---- shared/irq_seq_consts.svh ----
// constants for the interrupt sequencer: vector addresses, stack figures, timing
`ifndef IRQ_SEQ_CONSTS_SVH
`define IRQ_SEQ_CONSTS_SVH
`define VEC_RESET      14'h3FFE
`define VEC_TRAP       14'h3FFC
`define VEC_EXTERNAL   14'h3FFA
`define VEC_WIDE_TIMER 14'h3FF8
`define VEC_LINK       14'h3FF6
`define VEC_SERIAL     14'h3FF4
`define VEC_CORE_TIMER 14'h3FF2
`define VEC_GAUGE      14'h3FF0
`define STACK_BYTES    3'h5
`define SP_RESET       6'h3F
`define CCR_FIXED      8'hE0
`define CCR_MASK_BIT   3
`define STACK_OVERHEAD 10
`endif

// ---- shared/irq_seq_pkg.sv ----
// types for the interrupt sequencer
package irq_seq_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_PUSH,
        ST_VEC_HI,
        ST_VEC_LO,
        ST_PULL
    } seq_state_e;

    // one bit per hardware cause, in descending vector order
    typedef struct packed {
        logic external_line_flag;
        logic port_edge_flag;
        logic wide_timer;
        logic serial_link_controller_source;
        logic serial_transfer_done_flag;
        logic core_timer_source;
        logic gauge_sync_flag;
    } hw_req_s;

    // cpu register image saved on entry
    typedef struct packed {
        logic [7:0]  condition_code_reg;
        logic [7:0]  acc;
        logic [7:0]  idx;
        logic [13:0] pc;
    } cpu_state_s;
endpackage

// ---- verilog/irq_sequencer.sv ----
// interrupt and exception sequencer for an 8-bit microcontroller core
`timescale 1ns/1ps
`include "irq_seq_consts.svh"

// Contract
// - hardware requests wait for instruction end
// - service only if source enabled, and mask clear unless the entry came from a trap
// - stack state, set mask, then pick source
// - highest vector address wins among pending hardware
// - vectors fetched from top sixteen bytes
// - reset loads top vector, sets mask
// - trap ignores mask, uses second vector
// - pending hardware served before trap
// - mask blocks hardware sources but reset, except that a trap entry still picks them
// - exactly eight interrupt causes recognised
// - external line and port edges share vector
// - wide timer flags share one vector
// - link controller has own vector
// - serial transfer done has own vector
// - core overflow and real time share
// - gauge sync lowest vector, lowest priority
// - latency bounded: instruction plus ten cycles
// - return pulls state, resumes saved pc
// - masked requests stay latched until served
// - each entry pushes five stack bytes
module irq_sequencer (
    input  wire logic                    SYS_CLK_I,
    input  wire logic                    RST_B_I,
    input  wire logic                    INT_RST_I,
    input  wire irq_seq_pkg::hw_req_s    REQ_I,
    input  wire irq_seq_pkg::hw_req_s    ENABLE_I,
    input  wire logic                    INSN_DONE_I,
    input  wire logic                    TRAP_I,
    input  wire logic                    RETURN_I,
    input  wire logic                    MASK_CLR_I,
    input  wire logic                    MASK_SET_I,
    input  wire irq_seq_pkg::cpu_state_s CPU_STATE_I,
    input  wire logic [7:0]              MEM_RDATA_I,
    output logic                         MEM_RD_O,
    output logic                         MEM_WR_O,
    output logic [13:0]                  MEM_ADDR_O,
    output logic [7:0]                   MEM_WDATA_O,
    output logic                         CPU_HOLD_O,
    output logic                         PC_LOAD_O,
    output logic [13:0]                  PC_O,
    output logic                         MASK_O,
    output logic [7:0]                   RESTORE_DATA_O,
    output logic                         RESTORE_VALID_O,
    output logic                         EXTERNAL_ACK_O
);
    // ==========================================================
    // reset release
    logic [1:0] rst_sync_r;
    logic       rst_n;
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ==========================================================
    // source selection
    function automatic logic [13:0] pick_vector(input irq_seq_pkg::hw_req_s r);
        logic [13:0] v;
        v = `VEC_TRAP;
        if (r.external_line_flag || r.port_edge_flag) begin
            v = `VEC_EXTERNAL;
        end else if (r.wide_timer) begin
            v = `VEC_WIDE_TIMER;
        end else if (r.serial_link_controller_source) begin
            v = `VEC_LINK;
        end else if (r.serial_transfer_done_flag) begin
            v = `VEC_SERIAL;
        end else if (r.core_timer_source) begin
            v = `VEC_CORE_TIMER;
        end else if (r.gauge_sync_flag) begin
            v = `VEC_GAUGE;
        end
        return v;
    endfunction

    irq_seq_pkg::seq_state_e state_r;
    logic                    mask_r;
    logic                    trap_r;
    logic                    boot_r;
    logic [2:0]              cnt_r;
    logic [5:0]              sp_r;
    logic [13:0]             vec_r;
    logic [7:0]              vhi_r;
    irq_seq_pkg::cpu_state_s save_r;

    // requests are levels held by the sources' own latches until cleared there
    irq_seq_pkg::hw_req_s live;
    logic                 hw_pend;
    logic                 take;
    logic [7:0]           push_byte;
    assign live      = REQ_I & ENABLE_I;
    assign hw_pend   = (|live) && !mask_r;
    // a trap that lost to hardware stays pending; the return itself must finish first
    assign take      = INSN_DONE_I &&
                       (hw_pend || TRAP_I || (trap_r && !RETURN_I));
    // push order: pc low, pc high, idx, acc, ccr
    assign push_byte = (cnt_r == 3'h0) ? save_r.pc[7:0] :
                       (cnt_r == 3'h1) ? {2'h0, save_r.pc[13:8]} :
                       (cnt_r == 3'h2) ? save_r.idx :
                       (cnt_r == 3'h3) ? save_r.acc :
                       (save_r.condition_code_reg | `CCR_FIXED);

    // ==========================================================
    // sequencer
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_r         <= irq_seq_pkg::ST_VEC_HI;
            vec_r           <= `VEC_RESET;
            mask_r          <= 1'h1;
            boot_r          <= 1'h1;
            trap_r          <= 1'h0;
            cnt_r           <= 3'h0;
            sp_r            <= `SP_RESET;
            vhi_r           <= 8'h00;
            save_r          <= '0;
            MEM_RD_O        <= 1'h0;
            MEM_WR_O        <= 1'h0;
            MEM_ADDR_O      <= 14'h0000;
            MEM_WDATA_O     <= 8'h00;
            CPU_HOLD_O      <= 1'h1;
            PC_LOAD_O       <= 1'h0;
            PC_O            <= 14'h0000;
            MASK_O          <= 1'h1;
            RESTORE_DATA_O  <= 8'h00;
            RESTORE_VALID_O <= 1'h0;
            EXTERNAL_ACK_O  <= 1'h0;
        end else begin
            MEM_RD_O        <= 1'h0;
            MEM_WR_O        <= 1'h0;
            PC_LOAD_O       <= 1'h0;
            RESTORE_VALID_O <= 1'h0;
            EXTERNAL_ACK_O  <= 1'h0;
            MASK_O          <= mask_r;
            if (INT_RST_I) begin
                state_r    <= irq_seq_pkg::ST_VEC_HI;
                vec_r      <= `VEC_RESET;
                mask_r     <= 1'h1;
                boot_r     <= 1'h1;
                trap_r     <= 1'h0;
                sp_r       <= `SP_RESET;
                CPU_HOLD_O <= 1'h1;
            end else begin
                case (state_r)
                    irq_seq_pkg::ST_RUN: begin
                        if (MASK_SET_I) begin
                            mask_r <= 1'h1;
                        end else if (MASK_CLR_I) begin
                            mask_r <= 1'h0;
                        end
                        if (take) begin
                            save_r     <= CPU_STATE_I;
                            trap_r     <= trap_r || TRAP_I;
                            cnt_r      <= 3'h0;
                            CPU_HOLD_O <= 1'h1;
                            state_r    <= irq_seq_pkg::ST_PUSH;
                        end else if (RETURN_I && INSN_DONE_I) begin
                            cnt_r      <= 3'h0;
                            CPU_HOLD_O <= 1'h1;
                            state_r    <= irq_seq_pkg::ST_PULL;
                        end
                    end
                    irq_seq_pkg::ST_PUSH: begin
                        MEM_WR_O    <= 1'h1;
                        MEM_ADDR_O  <= {6'h00, 2'h3, sp_r};
                        MEM_WDATA_O <= push_byte;
                        sp_r        <= sp_r - 6'h01;
                        cnt_r       <= cnt_r + 3'h1;
                        if (cnt_r == `STACK_BYTES - 3'h1) begin
                            mask_r  <= 1'h1;
                            // hardware wins over the trap
                            vec_r   <= (|live) ? pick_vector(live) : `VEC_TRAP;
                            trap_r  <= trap_r && (|live);
                            EXTERNAL_ACK_O <= (|live) && (pick_vector(live) == `VEC_EXTERNAL);
                            state_r <= irq_seq_pkg::ST_VEC_HI;
                        end
                    end
                    irq_seq_pkg::ST_VEC_HI: begin
                        MEM_RD_O   <= 1'h1;
                        MEM_ADDR_O <= vec_r;
                        cnt_r      <= 3'h0;
                        state_r    <= irq_seq_pkg::ST_VEC_LO;
                    end
                    irq_seq_pkg::ST_VEC_LO: begin
                        cnt_r <= cnt_r + 3'h1;
                        if (cnt_r == 3'h0) begin
                            MEM_RD_O   <= 1'h1;
                            MEM_ADDR_O <= vec_r | 14'h0001;
                            vhi_r      <= MEM_RDATA_I;
                        end else begin
                            PC_LOAD_O  <= 1'h1;
                            PC_O       <= {vhi_r[5:0], MEM_RDATA_I};
                            CPU_HOLD_O <= 1'h0;
                            boot_r     <= 1'h0;
                            state_r    <= irq_seq_pkg::ST_RUN;
                        end
                    end
                    irq_seq_pkg::ST_PULL: begin
                        // one read issued per cycle, data returned a cycle later
                        cnt_r <= cnt_r + 3'h1;
                        if (cnt_r < `STACK_BYTES) begin
                            MEM_RD_O   <= 1'h1;
                            MEM_ADDR_O <= {6'h00, 2'h3, sp_r + 6'h01};
                            sp_r       <= sp_r + 6'h01;
                        end
                        if (cnt_r != 3'h0) begin
                            RESTORE_VALID_O <= 1'h1;
                            RESTORE_DATA_O  <= MEM_RDATA_I;
                            if (cnt_r == 3'h1) begin
                                mask_r <= MEM_RDATA_I[`CCR_MASK_BIT];
                            end
                        end
                        if (cnt_r == `STACK_BYTES) begin
                            CPU_HOLD_O <= 1'h0;
                            state_r    <= irq_seq_pkg::ST_RUN;
                        end
                    end
                    default: begin
                        state_r <= irq_seq_pkg::ST_RUN;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    sequence entry_s;
        state_r == irq_seq_pkg::ST_RUN && take && !INT_RST_I;
    endsequence

    mask_blocks_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        (state_r == irq_seq_pkg::ST_RUN && mask_r && !TRAP_I && !trap_r) |-> !take)
        else $error("hardware request taken while masked");

    wait_done_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        (state_r == irq_seq_pkg::ST_RUN && !INSN_DONE_I) |-> !take)
        else $error("entry began before instruction end");

    five_push_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        entry_s |=> (MEM_WR_O == 1'h0) ##1 MEM_WR_O [*5] ##1 !MEM_WR_O)
        else $error("entry did not push five bytes");

    mask_set_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        entry_s |-> ##6 mask_r)
        else $error("mask not set after stacking");

    latency_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        entry_s |-> ##[1:10] (PC_LOAD_O || INT_RST_I))
        else $error("entry exceeded ten cycle overhead");

    trap_vec_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        (state_r == irq_seq_pkg::ST_PUSH && cnt_r == 3'h4 && (|live) && !INT_RST_I)
        |=> vec_r != `VEC_TRAP)
        else $error("trap served before pending hardware");

    vec_range_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        MEM_RD_O && state_r == irq_seq_pkg::ST_VEC_LO |-> MEM_ADDR_O[13:4] == 10'h3FF)
        else $error("vector read outside table");

    boot_vec_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        $rose(INT_RST_I) |=> vec_r == `VEC_RESET && mask_r)
        else $error("internal reset did not select top vector");

    pull_mask_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        (state_r == irq_seq_pkg::ST_PULL && cnt_r == 3'h1 && !INT_RST_I)
        |=> mask_r == $past(MEM_RDATA_I[`CCR_MASK_BIT]))
        else $error("return did not restore mask");

    ext_ack_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        EXTERNAL_ACK_O |-> (state_r == irq_seq_pkg::ST_VEC_HI && vec_r == `VEC_EXTERNAL))
        else $error("external ack without external vector");

    trap_taken_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        (state_r == irq_seq_pkg::ST_RUN && INSN_DONE_I && TRAP_I && !INT_RST_I)
        |=> state_r == irq_seq_pkg::ST_PUSH)
        else $error("trap not taken");

    trap_last_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        (state_r == irq_seq_pkg::ST_PUSH && cnt_r == 3'h4 && !(|live) && !INT_RST_I)
        |=> (vec_r == `VEC_TRAP && !trap_r))
        else $error("trap vector or pending flag wrong");

    latched_take_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        (state_r == irq_seq_pkg::ST_RUN && (|live) && !mask_r && INSN_DONE_I && !INT_RST_I)
        |=> state_r == irq_seq_pkg::ST_PUSH)
        else $error("unmasked pending request not taken");

    push_window_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        MEM_WR_O |-> MEM_ADDR_O[13:6] == 8'h03)
        else $error("push outside stack window");

    load_release_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        PC_LOAD_O |-> !CPU_HOLD_O)
        else $error("pc loaded while core still held");

    boot_hold_a : assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        boot_r |-> CPU_HOLD_O)
        else $error("core released during reset vector fetch");
endmodule

// ---- dv/vector_mem_model.sv ----
// memory partner: vector table plus stack ram answering the sequencer bus
`timescale 1ns/1ps
module vector_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [13:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic [7:0]       rdata_o
);
    logic [7:0] mem [0:16383];
    // ==========================================
    // vector table, one pair per slot
    initial begin
        for (int j = 0; j < 8; j++) begin
            mem[14'h3FF0 + 14'(2 * j)] = 8'h10 + 8'(j);
            mem[14'h3FF1 + 14'(2 * j)] = 8'hA0 + 8'(j);
        end
    end
    // ==========================================
    // bus response
    // data answers within the strobe cycle; inverted otherwise so stale bytes never pass
    assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
`include "irq_seq_consts.svh"
module tb;
    logic SYS_CLK_I, RST_B_I, INT_RST_I, INSN_DONE_I, TRAP_I, RETURN_I, MASK_CLR_I, MASK_SET_I;
    irq_seq_pkg::hw_req_s    REQ_I, ENABLE_I;
    irq_seq_pkg::cpu_state_s CPU_STATE_I;
    logic [7:0]  MEM_RDATA_I, MEM_WDATA_O, RESTORE_DATA_O;
    logic [13:0] MEM_ADDR_O, PC_O;
    logic MEM_RD_O, MEM_WR_O, CPU_HOLD_O, PC_LOAD_O, MASK_O, RESTORE_VALID_O, EXTERNAL_ACK_O;
    int n_mismatch = 0;
    int total_checks = 0;
    irq_sequencer u_irq_sequencer (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
        .INT_RST_I(INT_RST_I), .REQ_I(REQ_I), .ENABLE_I(ENABLE_I), .INSN_DONE_I(INSN_DONE_I),
        .TRAP_I(TRAP_I), .RETURN_I(RETURN_I), .MASK_CLR_I(MASK_CLR_I), .MASK_SET_I(MASK_SET_I),
        .CPU_STATE_I(CPU_STATE_I), .MEM_RDATA_I(MEM_RDATA_I), .MEM_RD_O(MEM_RD_O),
        .MEM_WR_O(MEM_WR_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
        .CPU_HOLD_O(CPU_HOLD_O), .PC_LOAD_O(PC_LOAD_O), .PC_O(PC_O), .MASK_O(MASK_O),
        .RESTORE_DATA_O(RESTORE_DATA_O), .RESTORE_VALID_O(RESTORE_VALID_O),
        .EXTERNAL_ACK_O(EXTERNAL_ACK_O));
    vector_mem_model u_vector_mem_model (.clk_i(SYS_CLK_I), .rd_i(MEM_RD_O), .wr_i(MEM_WR_O),
        .addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O), .rdata_o(MEM_RDATA_I));
    // ==========================================
    // helpers
    initial begin
        SYS_CLK_I = 1'b0;
        forever #5 SYS_CLK_I = ~SYS_CLK_I;
    end
    function automatic logic [13:0] vec(input int s);
        return 14'h10A0 + 14'(s) * 14'h0101;
    endfunction
    task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_boot();
        logic seen;
        seen = 1'b0;
        for (int c = 0; c < 30 && !seen; c++) begin
            @(posedge SYS_CLK_I); #1;
            if (PC_LOAD_O === 1'b1) begin
                seen = 1'b1;
                chk("reset pc", vec(7), PC_O);
            end
        end
        chk("reset load seen", 14'h1, {13'h0, seen});
        @(posedge SYS_CLK_I); #1;
        chk("reset mask", 14'h1, {13'h0, MASK_O});
        if (!seen) summarize();
    endtask
    task automatic mask(input logic set_n_clr);
        @(negedge SYS_CLK_I); MASK_SET_I = set_n_clr; MASK_CLR_I = ~set_n_clr;
        @(negedge SYS_CLK_I); MASK_SET_I = 1'b0; MASK_CLR_I = 1'b0;
    endtask
    task automatic idle(input logic [6:0] req, input logic [6:0] en, input logic done);
        @(negedge SYS_CLK_I); REQ_I = req; ENABLE_I = en; INSN_DONE_I = done;
        repeat (12) begin
            @(posedge SYS_CLK_I); #1;
            chk("no entry hold", 14'h0, {13'h0, CPU_HOLD_O});
        end
        @(negedge SYS_CLK_I); INSN_DONE_I = 1'b0; ENABLE_I = 7'h7F;
    endtask
    task automatic do_entry(input logic [6:0] req, input logic trap, input int slot);
        int n;
        logic seen;
        logic [7:0] push_exp [5];
        logic ack;
        n = 0;
        seen = 1'b0;
        ack = 1'b0;
        push_exp = '{8'h34, 8'h12, 8'h33, 8'h44, 8'hE0};
        @(negedge SYS_CLK_I); REQ_I = req; ENABLE_I = 7'h7F; TRAP_I = trap; INSN_DONE_I = 1'b1;
        @(negedge SYS_CLK_I); INSN_DONE_I = 1'b0; TRAP_I = 1'b0;
        for (int c = 1; c <= 14 && !seen; c++) begin
            @(posedge SYS_CLK_I); #1;
            if (EXTERNAL_ACK_O === 1'b1) ack = 1'b1;
            if (MEM_WR_O === 1'b1) begin
                chk("push addr", 14'h00FF - 14'(n), MEM_ADDR_O);
                if (n < 5) chk("push data", {6'h0, push_exp[n]}, {6'h0, MEM_WDATA_O});
                n++;
            end
            if (PC_LOAD_O === 1'b1) begin
                seen = 1'b1;
                chk("entry pc", vec(slot), PC_O);
                chk("latency ok", 14'h1, {13'h0, c <= `STACK_OVERHEAD});
            end
        end
        chk("push count", 14'h5, 14'(n));
        chk("external ack", {13'h0, slot == 5}, {13'h0, ack});
        chk("entry mask", 14'h1, {13'h0, MASK_O});
        @(negedge SYS_CLK_I); REQ_I = '0;
        if (!seen) summarize();
    endtask
    task automatic do_return();
        int n;
        logic [7:0] got [5];
        n = 0;
        @(negedge SYS_CLK_I); RETURN_I = 1'b1; INSN_DONE_I = 1'b1;
        @(negedge SYS_CLK_I); RETURN_I = 1'b0; INSN_DONE_I = 1'b0;
        for (int c = 1; c <= 12; c++) begin
            @(posedge SYS_CLK_I); #1;
            if (RESTORE_VALID_O === 1'b1 && n < 5) begin
                got[n] = RESTORE_DATA_O;
                n++;
            end
        end
        chk("pull count", 14'h5, 14'(n));
        chk("pull state", 14'h0,
            (n == 5 && {got[0], got[1], got[2], got[3], got[4]} === 40'hE044331234)
            ? 14'h0 : 14'h1);
        chk("return mask", 14'h0, {13'h0, MASK_O});
        chk("return hold", 14'h0, {13'h0, CPU_HOLD_O});
    endtask
    // ==========================================
    // main sequence
    initial begin
        RST_B_I = 1'b0; INT_RST_I = 1'b0; INSN_DONE_I = 1'b0; TRAP_I = 1'b0; RETURN_I = 1'b0;
        MASK_CLR_I = 1'b0; MASK_SET_I = 1'b0; REQ_I = '0; ENABLE_I = 7'h7F;
        CPU_STATE_I = {8'hE0, 8'h44, 8'h33, 14'h1234};
        repeat (20) @(negedge SYS_CLK_I);
        RST_B_I = 1'b1;
        wait_boot();
        idle(7'h40, 7'h7F, 1'b1);
        mask(1'b0);
        do_entry(7'h40, 1'b0, 5);
        do_return();
        for (int i = 6; i >= 0; i--) begin
            do_entry(7'h7F >> (6 - i), 1'b0, (i == 6) ? 5 : i);
            do_return();
        end
        idle(7'h7F, 7'h00, 1'b1);
        idle(7'h7F, 7'h7F, 1'b0);
        do_entry(7'h01, 1'b1, 0);
        do_return();
        do_entry(7'h00, 1'b0, 6);
        do_return();
        mask(1'b1);
        do_entry(7'h00, 1'b1, 6);
        do_return();
        @(negedge SYS_CLK_I); INT_RST_I = 1'b1;
        @(negedge SYS_CLK_I); INT_RST_I = 1'b0;
        wait_boot();
        summarize();
    end
endmodule
